/* verilog/pmb_top.sv */
// operating mode sequencer and boost converter digital control
`timescale 1ns/1ps
`default_nettype none
module pmb_top #(
  parameter int SETTLE_CYCLES = pmb_pkg::SETTLE_CYC
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       supply_low,
  input  wire logic       thermal_trip,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [4:0] loop_demand,
  output logic [7:0]      reg_rdata,
  output logic            core_enable,
  output logic            boost_switch,
  output logic            boost_pfm,
  output logic            boost_pwm,
  output logic            leds_blank,
  output logic            active_load,
  output logic [7:0]      out_level,
  output logic [1:0]      color_sel
);
  // soft reset is a registered one-clock pulse, held off the async reset tree
  logic                    soft_rst_q;
  logic                    por_q;
  logic [7:0]              enables_q;
  logic [7:0]              rate_q;
  logic [7:0]              level_q;
  logic [7:0]              load_q;
  logic [23:0]             tmr_q;
  logic [23:0]             tmr_d;
  logic [7:0]              rdata_d;
  pmb_pkg::pmb_state_t     st_q;
  pmb_pkg::pmb_state_t     st_d;
  logic                    sw_raw;
  logic                    core_q;
  logic                    sw_q;
  logic                    pfm_q;
  logic                    pwm_q;
  logic                    blank_q;
  logic                    aload_q;

  wire wr_enables = reg_wr && reg_addr == pmb_pkg::ADDR_ENABLES;
  wire wr_rate    = reg_wr && reg_addr == pmb_pkg::ADDR_RATE_SEL;
  wire wr_level   = reg_wr && reg_addr == pmb_pkg::ADDR_OUT_LEVEL;
  wire wr_load    = reg_wr && reg_addr == pmb_pkg::ADDR_LOAD_CTRL;
  wire wr_softrst = reg_wr && reg_addr == pmb_pkg::ADDR_SOFT_RESET;
  wire in_reset   = soft_rst_q || por_q;
  wire boost_en   = enables_q[pmb_pkg::BIT_BOOST_EN];
  wire stby_rel   = enables_q[pmb_pkg::BIT_STBY_REL];
  wire tmr_done   = tmr_q >= 24'(SETTLE_CYCLES - 1);
  // boost enable rising while in normal mode restarts the soft start
  logic boost_en_q;
  wire  boost_rise = boost_en && !boost_en_q;

  // por flop takes the monitor level by clock, reset tree takes only constants
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      por_q      <= 1'b1;
      soft_rst_q <= 1'b0;
    end
    else
    begin
      por_q      <= supply_low;
      soft_rst_q <= wr_softrst;
    end
  end

  // register file: writes accepted in any order, ignored while soft reset or por is active
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      enables_q <= pmb_pkg::RST_ENABLES;
      rate_q    <= pmb_pkg::RST_RATE_SEL;
      level_q   <= pmb_pkg::RST_OUT_LEVEL;
      load_q    <= pmb_pkg::RST_LOAD_CTRL;
    end
    else if (in_reset)
    begin
      enables_q <= pmb_pkg::RST_ENABLES;
      rate_q    <= pmb_pkg::RST_RATE_SEL;
      level_q   <= pmb_pkg::RST_OUT_LEVEL;
      load_q    <= pmb_pkg::RST_LOAD_CTRL;
    end
    else
    begin
      if (wr_enables)
        enables_q <= reg_wdata;
      if (wr_rate)
        rate_q <= reg_wdata;
      if (wr_level)
        level_q <= reg_wdata;
      if (wr_load)
        load_q <= reg_wdata;
    end
  end

  // mode sequencer
  always_comb
  begin
    st_d  = st_q;
    tmr_d = (tmr_done) ? tmr_q : tmr_q + 24'h000001;
    case (st_q)
      pmb_pkg::ST_RESET:
      begin
        tmr_d = 24'h000000;
        if (!in_reset)
          st_d = pmb_pkg::ST_STANDBY;
      end
      pmb_pkg::ST_STANDBY:
      begin
        tmr_d = 24'h000000;
        if (stby_rel)
          st_d = pmb_pkg::ST_STARTUP;
      end
      pmb_pkg::ST_STARTUP:
      begin
        if (thermal_trip)
          tmr_d = 24'h000000;
        else if (tmr_done)
        begin
          tmr_d = 24'h000000;
          st_d  = boost_en ? pmb_pkg::ST_BSTART : pmb_pkg::ST_NORMAL;
        end
      end
      pmb_pkg::ST_BSTART:
      begin
        if (thermal_trip)
        begin
          tmr_d = 24'h000000;
          st_d  = pmb_pkg::ST_STARTUP;
        end
        else if (!boost_en)
          st_d = pmb_pkg::ST_NORMAL;
        else if (tmr_done)
          st_d = pmb_pkg::ST_NORMAL;
      end
      pmb_pkg::ST_NORMAL:
      begin
        tmr_d = 24'h000000;
        if (thermal_trip)
          st_d = pmb_pkg::ST_STARTUP;
        else if (boost_rise)
          st_d = pmb_pkg::ST_BSTART;
      end
      default:
      begin
        st_d  = pmb_pkg::ST_RESET;
        tmr_d = 24'h000000;
      end
    endcase
    if (in_reset)
      st_d = pmb_pkg::ST_RESET;
    else if (!stby_rel)
      st_d = pmb_pkg::ST_STANDBY;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q       <= pmb_pkg::ST_RESET;
      tmr_q      <= 24'h000000;
      boost_en_q <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      tmr_q      <= tmr_d;
      boost_en_q <= boost_en;
    end
  end

  // priority rate decode; zero field falls back to the slowest rate
  wire [4:0] period = rate_q[2] ? pmb_pkg::PER_FAST :
                      rate_q[1] ? pmb_pkg::PER_MID  : pmb_pkg::PER_SLOW;
  wire in_bstart = st_q == pmb_pkg::ST_BSTART;
  wire in_normal = st_q == pmb_pkg::ST_NORMAL;
  // rise cycle held off so no pwm pulse slips in ahead of the soft start
  wire boost_run = boost_en && (in_bstart || (in_normal && !boost_rise));
  // pfm soft start uses minimum pulses only
  wire [4:0] demand = in_bstart ? pmb_pkg::MIN_ON : loop_demand;

  // switch timing counts mclk, the single oscillator
  pmb_switch_gen u_sw (
    .mclk   (mclk),
    .resetn (resetn),
    .run    (boost_run),
    .period (period),
    .demand (demand),
    .sw_on  (sw_raw)
  );

  always_comb
  begin
    rdata_d = 8'h00;
    case (reg_addr)
      pmb_pkg::ADDR_ENABLES:    rdata_d = enables_q;
      pmb_pkg::ADDR_RATE_SEL:   rdata_d = rate_q;
      pmb_pkg::ADDR_OUT_LEVEL:  rdata_d = level_q;
      pmb_pkg::ADDR_LOAD_CTRL:  rdata_d = load_q;
      pmb_pkg::ADDR_STATUS:     rdata_d = {2'b00, thermal_trip, st_q};
      pmb_pkg::ADDR_SOFT_RESET: rdata_d = 8'h00;
      default:                  rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata <= 8'h00;
      core_q    <= 1'b0;
      sw_q      <= 1'b0;
      pfm_q     <= 1'b0;
      pwm_q     <= 1'b0;
      blank_q   <= 1'b1;
      aload_q   <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd ? rdata_d : 8'h00;
      core_q    <= in_bstart || in_normal;
      sw_q      <= sw_raw;
      pfm_q     <= boost_run && in_bstart;
      pwm_q     <= boost_run && in_normal;
      blank_q   <= !in_normal;
      aload_q   <= boost_run && load_q[pmb_pkg::BIT_AUTOLOAD];
    end
  end

  assign core_enable  = core_q;
  assign boost_switch = sw_q;
  assign boost_pfm    = pfm_q;
  assign boost_pwm    = pwm_q;
  assign leds_blank   = blank_q;
  assign active_load  = aload_q;
  assign out_level    = level_q;
  assign color_sel    = enables_q[pmb_pkg::BIT_COLOR_SEL_LO +: 2];
endmodule
`default_nettype wire

/* verilog/pmb_pkg.sv */
// constants and types for the power mode and boost control block
`default_nettype none
package pmb_pkg;
  localparam logic [7:0] ADDR_ENABLES     = 8'h08;
  localparam logic [7:0] ADDR_RATE_SEL    = 8'h0E;
  localparam logic [7:0] ADDR_OUT_LEVEL   = 8'h0F;
  localparam logic [7:0] ADDR_LOAD_CTRL   = 8'h11;
  localparam logic [7:0] ADDR_STATUS      = 8'h12;
  localparam logic [7:0] ADDR_SOFT_RESET  = 8'h60;
  localparam logic [7:0] RST_ENABLES      = 8'h00;
  localparam logic [7:0] RST_RATE_SEL     = 8'h07;
  localparam logic [7:0] RST_OUT_LEVEL    = 8'h3F;
  localparam logic [7:0] RST_LOAD_CTRL    = 8'h01;
  localparam int         BIT_BOOST_EN     = 5;
  localparam int         BIT_STBY_REL     = 6;
  localparam int         BIT_COLOR_SEL_LO = 0;
  localparam int         BIT_AUTOLOAD     = 0;
  localparam int         CLK_HZ           = 20_000_000;
  localparam int         SETTLE_MS        = 10;
  localparam int         SETTLE_CYC       = SETTLE_MS * (CLK_HZ / 1000);
  // switch period in clocks per rate; 20 MHz clock cannot hit 1.67 MHz exactly
  localparam logic [4:0] PER_FAST         = 5'h0A;
  localparam logic [4:0] PER_MID          = 5'h0C;
  localparam logic [4:0] PER_SLOW         = 5'h14;
  localparam int         MIN_PULSE_NS     = 25;
  localparam int         MIN_PULSE_CYC    = (MIN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [4:0] MIN_ON           = 5'(MIN_PULSE_CYC);
  localparam int         DUTY_MAX_PCT     = 80;
  typedef enum logic [4:0] {
    ST_RESET   = 5'h01,
    ST_STANDBY = 5'h02,
    ST_STARTUP = 5'h04,
    ST_BSTART  = 5'h08,
    ST_NORMAL  = 5'h10
  } pmb_state_t;
endpackage
`default_nettype wire

/* verilog/pmb_switch_gen.sv */
// switch pulse generator with minimum and maximum on-time
`timescale 1ns/1ps
`default_nettype none
module pmb_switch_gen (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [4:0] period,
  input  wire logic [4:0] demand,
  output logic            sw_on
);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  wire  [9:0] max_prod = {5'h00, period} * 10'(pmb_pkg::DUTY_MAX_PCT / 10);
  wire  [9:0] max_quo  = max_prod / 10'h00A;
  wire  [4:0] max_on   = max_quo[4:0];
  // clamp demand between one minimum pulse and the duty ceiling
  wire  [4:0] lo_clip  = (demand < pmb_pkg::MIN_ON) ? pmb_pkg::MIN_ON : demand;
  wire  [4:0] on_len   = (lo_clip > max_on) ? max_on : lo_clip;
  assign cnt_d = (!run || cnt_q >= period - 5'h01) ? 5'h00 : cnt_q + 5'h01;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      cnt_q <= 5'h00;
    else
      cnt_q <= cnt_d;
  end
  assign sw_on = run && (cnt_q < on_len);
endmodule
`default_nettype wire

/* dv/pmb_checker.sv */
// assertion checker for the power mode and boost control block
`timescale 1ns/1ps
`default_nettype none
module pmb_checker #(
  parameter int SETTLE_CYCLES = 20
) (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       supply_low,
  input wire logic       thermal_trip,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       core_enable,
  input wire logic       boost_switch,
  input wire logic       boost_pfm,
  input wire logic       boost_pwm,
  input wire logic       leds_blank,
  input wire logic [7:0] out_level,
  input wire logic [1:0] color_sel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  int pfm_cnt_q;
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      pfm_cnt_q <= 0;
    else
      pfm_cnt_q <= boost_pfm ? pfm_cnt_q + 1 : 0;
  chk_reset_reg_zero: assert property ($past(reg_rd && reg_addr == 8'h60) |-> reg_rdata == 8'h00)
    else $error("reset register read not zero");
  chk_soft_reset_defaults: assert property (reg_wr && reg_addr == 8'h60 |-> ##[2:4]
    (out_level == 8'h3F && color_sel == 2'b00 && !core_enable))
    else $error("soft reset did not restore defaults");
  chk_supply_holds_reset: assert property (supply_low[*4] |-> !core_enable && !boost_switch)
    else $error("core active while supply low");
  chk_thermal_stop: assert property (thermal_trip[*3] |-> !core_enable)
    else $error("core active during thermal trip");
  chk_pfm_blanks_leds: assert property (boost_pfm |-> leds_blank && core_enable && !boost_pwm)
    else $error("leds not blanked in soft start");
  chk_pfm_then_pwm: assert property ($rose(boost_pwm) |->
    pfm_cnt_q >= SETTLE_CYCLES - 1 && pfm_cnt_q <= SETTLE_CYCLES + 1)
    else $error("pwm not preceded by full pfm interval");
  chk_switch_stopped: assert property ((!boost_pfm && !boost_pwm)[*4] |-> !boost_switch)
    else $error("switching while boost stopped");
  chk_duty_bound: assert property (boost_switch |-> ##[1:16] !boost_switch)
    else $error("switch on time unbounded");
  chk_pwm_normal: assert property (boost_pwm |-> core_enable && !leds_blank)
    else $error("pwm outside normal mode");
  cover property (boost_pfm ##1 boost_pwm);
  cover property (thermal_trip && core_enable);
  cover property (reg_wr && reg_addr == 8'h60);
endmodule
bind pmb_top pmb_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.mclk, .resetn, .supply_low,
  .thermal_trip, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .core_enable, .boost_switch,
  .boost_pfm, .boost_pwm, .leds_blank, .out_level, .color_sel);
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the power mode and boost control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       mclk, resetn, supply_low, thermal_trip, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, out_level, rv;
  logic       core_enable, boost_switch, boost_pfm, boost_pwm, leds_blank, active_load;
  logic [4:0] loop_demand;
  logic [1:0] color_sel;
  int         n_fail, cmp_count, j;
  logic [7:0] rates [5] = '{8'h07, 8'h03, 8'h01, 8'h04, 8'h02};
  logic [7:0] pers  [5] = '{8'h0A, 8'h0C, 8'h14, 8'h0A, 8'h0C};
  pmb_top #(.SETTLE_CYCLES(20)) DUT (.mclk, .resetn, .supply_low, .thermal_trip, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .loop_demand, .reg_rdata, .core_enable, .boost_switch,
    .boost_pfm, .boost_pwm, .leds_blank, .active_load, .out_level, .color_sel);
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    rv = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string m);
    rd(a);
    chk(rv, e, m);
  endtask
  // poll the status register; a hang ends the run
  task automatic st(input logic [4:0] s);
    int i;
    rv = 8'h00;
    for (i = 0; i < 300 && rv[4:0] !== s; i++)
      rd(8'h12);
    chk({3'h0, rv[4:0]}, {3'h0, s}, "state");
    if (rv[4:0] !== s)
      summarize();
  endtask
  // skip two rises so a rate change settles first
  task automatic per(input logic [7:0] e);
    int i, k, r;
    logic p;
    p = 1'b1;
    r = 0;
    k = 0;
    for (i = 0; i < 200 && r < 3; i++)
    begin
      @(negedge mclk);
      k++;
      if (boost_switch === 1'b1 && !p && r++ < 2)
        k = 0;
      p = boost_switch;
    end
    chk(8'(k), e, "period");
    if (r < 3)
    begin
      n_fail++;
      summarize();
    end
  endtask
  initial
  begin
    resetn = 1'b0;
    supply_low = 1'b1;
    thermal_trip = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    loop_demand = 5'h05;
    n_fail = 0;
    cmp_count = 0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    rc(8'h12, 8'h01, "por hold");
    @(posedge mclk);
    supply_low <= 1'b0;
    st(pmb_pkg::ST_STANDBY);
    rc(8'h08, 8'h00, "enables");
    rc(8'h0E, 8'h07, "rate");
    rc(8'h0F, 8'h3F, "level");
    rc(8'h11, 8'h01, "load");
    rc(8'h60, 8'h00, "reset reg");
    rc(8'h33, 8'h00, "unmapped");
    $display("test reset values done");
    wr(8'h0F, 8'hFF);
    wr(8'h0E, 8'h01);
    rc(8'h0F, 8'hFF, "level write");
    chk(core_enable, 1'b0, "standby");
    wr(8'h08, 8'h63);
    st(pmb_pkg::ST_STARTUP);
    st(pmb_pkg::ST_BSTART);
    chk(leds_blank, 1'b1, "blank");
    chk(boost_pfm, 1'b1, "pfm");
    st(pmb_pkg::ST_NORMAL);
    chk(boost_pwm, 1'b1, "pwm");
    chk(color_sel, 2'b11, "color");
    chk(out_level, 8'hFF, "level out");
    per(8'h14);
    for (j = 0; j < 5; j++)
    begin
      wr(8'h0E, rates[j]);
      per(pers[j]);
    end
    @(posedge mclk);
    loop_demand <= 5'h00;
    per(8'h0C);
    @(posedge mclk);
    loop_demand <= 5'h1F;
    per(8'h0C);
    @(posedge mclk);
    loop_demand <= 5'h05;
    $display("test boost start and rates done");
    @(posedge mclk);
    thermal_trip <= 1'b1;
    st(pmb_pkg::ST_STARTUP);
    chk(core_enable, 1'b0, "thermal");
    @(posedge mclk);
    thermal_trip <= 1'b0;
    st(pmb_pkg::ST_BSTART);
    st(pmb_pkg::ST_NORMAL);
    $display("test thermal done");
    chk(active_load, 1'b1, "load on");
    wr(8'h11, 8'h00);
    repeat (3) @(negedge mclk);
    chk(active_load, 1'b0, "load off");
    wr(8'h08, 8'h40);
    repeat (30) @(negedge mclk);
    chk(boost_pwm, 1'b0, "stopped");
    chk(boost_switch, 1'b0, "no switching");
    wr(8'h08, 8'h60);
    st(pmb_pkg::ST_BSTART);
    chk(boost_pwm, 1'b0, "no early pwm");
    st(pmb_pkg::ST_NORMAL);
    $display("test boost stop done");
    @(posedge mclk);
    supply_low <= 1'b1;
    repeat (4) @(posedge mclk);
    rc(8'h12, 8'h01, "supply low");
    chk(core_enable, 1'b0, "supply low core");
    rc(8'h0F, 8'h3F, "supply low level");
    @(posedge mclk);
    supply_low <= 1'b0;
    st(pmb_pkg::ST_STANDBY);
    wr(8'h08, 8'h43);
    wr(8'h0E, 8'h02);
    wr(8'h11, 8'h00);
    st(pmb_pkg::ST_NORMAL);
    wr(8'h60, 8'hA5);
    st(pmb_pkg::ST_STANDBY);
    rc(8'h08, 8'h00, "enables");
    rc(8'h0E, 8'h07, "rate");
    rc(8'h11, 8'h01, "load");
    $display("test resets done");
    summarize();
  end
endmodule
`default_nettype wire
